// ===== logic/ppc_pkg.sv
// constants, field layout and types of the pixel clock and power control block
// assumes: registers sit in the crystal clock domain, 32-bit dword access
package ppc_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [15:0] PIX_CTL_OFS    = 16'h7000;
   localparam logic [15:0] PIX_CFG0_OFS   = 16'h7004;
   localparam logic [15:0] PIX_CFG1_OFS   = 16'h7008;
   localparam logic [15:0] SYS_CTL_OFS    = 16'h700c;
   localparam logic [15:0] SYS_CFG0_OFS   = 16'h7010;
   localparam logic [15:0] SYS_CFG1_OFS   = 16'h7014;
   localparam logic [15:0] PM_CTL_OFS     = 16'h7020;
   localparam logic [15:0] SPACE_BASE     = 16'h7000;
   localparam logic [15:0] SPACE_LAST     = 16'h7fff;

   // ------------------------------------------------------------
   // pixel pll control fields and reset values
   // ------------------------------------------------------------
   localparam int GATE_BIT    = 31;
   localparam int LOCK1_BIT   = 5;
   localparam int LOCK0_BIT   = 4;
   localparam int BYPASS1_BIT = 3;
   localparam int BYPASS0_BIT = 2;
   localparam int HOLD1_BIT   = 1;
   localparam int HOLD0_BIT   = 0;
   localparam logic GATE_RST    = 1'b1;
   localparam logic BYPASS1_RST = 1'b1;
   localparam logic BYPASS0_RST = 1'b1;
   localparam logic HOLD1_RST   = 1'b1;
   localparam logic HOLD0_RST   = 1'b1;
   localparam logic LOCK_RST    = 1'b0;

   // ------------------------------------------------------------
   // stage configuration: range 22:20, divq 18:16, divr 12:8, divf 7:0
   // ------------------------------------------------------------
   localparam logic [31:0] CFG_WR_MASK = 32'h0077_1fff;
   localparam logic [31:0] CFG_RST     = 32'h0000_0000;
   localparam logic [31:0] SYS_WR_MASK = 32'hffff_ffff;
   localparam logic [31:0] SYS_RST     = 32'h0000_0000;

   // ------------------------------------------------------------
   // power manager control fields
   // ------------------------------------------------------------
   localparam int          PM_AUTO_BIT    = 0;
   localparam int          PM_SUSP_BIT    = 4;
   localparam int          PM_QUIET_BIT   = 5;
   localparam int          PM_CONF_BIT    = 6;
   localparam logic [31:0] PM_WR_MASK     = 32'h0000_0001;
   localparam logic [31:0] PM_RST         = 32'h0000_0000;

   // lock time software must wait, for reference only
   localparam int LOCK_TIME_US = 100;

   // link power states as reported by the usb core
   typedef enum logic [1:0] {
      PPC_L0, PPC_L1, PPC_L2, PPC_L3
   } ppc_lpm_t;

   typedef enum logic [1:0] {
      PPC_U0, PPC_U1, PPC_U2, PPC_U3
   } ppc_ulink_t;

   // power manager reaction
   typedef enum logic [2:0] {
      PPC_PM_RUN, PPC_PM_IDLE, PPC_PM_SUSPEND, PPC_PM_OFF
   } ppc_pm_t;

endpackage

// ===== logic/ppc_lock_sync.sv
// synchroniser with agreement filter for asynchronous level inputs
// assumes: inputs come from outside the clk domain (pll lock detectors)
`timescale 1ns/100ps
module ppc_lock_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk,      // crystal clock
   input  wire logic             sys_rst,  // async reset, high
   input  wire logic [WIDTH-1:0] async_in, // raw level
   output logic      [WIDTH-1:0] sync_out  // filtered level
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] agree;

   // first flop feeds stage2 only
   assign agree = ~(stage2 ^ stage3);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta     <= '0;
         stage2   <= '0;
         stage3   <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         stage2   <= meta;
         stage3   <= stage2;
         sync_out <= (agree & stage3) | (~agree & sync_out);
      end
   end

endmodule

// ===== logic/ppc_clock_power.sv
// pixel pll control, stage output steering and link power reaction
// assumes: clk is the crystal clock; csr port driven by the control endpoint
// logic in the same domain; stage clocks come from the analog pll macro
`timescale 1ns/100ps

// Functional notes
// - register bank runs on the crystal clock, usable before any pll runs.
// - decode pixel, system pll and power manager registers at their offsets.
// - 7018h-701Ch and 7024h-7FFFh are reserved, read zero, ignore writes.
// - gate bit set stops pixel derived clocks; cleared restarts them; resets set.
// - bit 5 shows stage 1 lock, zero after reset, asynchronous source.
// - bit 4 shows stage 0 lock, zero after reset, asynchronous source.
// - stage 0 bypass powers stage 0 down, node follows reference input.
// - stage 1 hold powers stage 1 down and drives both outputs low.
// - stage 0 hold powers stage 0 down and drives stage 0 node low.
// - in sleep state L1 no module is powered down.
// - L2 treated as suspend; L3 stops all data signaling.
// - U0 means configured, only after plls and datapath are set up.
// - U1 and U2 take no power action; U3 treated as suspend.
module ppc_clock_power (
   input  wire logic        clk,                       // crystal clock
   input  wire logic        sys_rst,                   // async reset, high
   input  wire logic        csr_rd,                    // read strobe
   input  wire logic        csr_wr,                    // write strobe
   input  wire logic [15:0] csr_addr,                  // byte address
   input  wire logic [31:0] csr_wdata,                 // write data
   output logic      [31:0] csr_rdata,                 // read data
   output logic             csr_ack,                   // access done
   input  wire logic        pixel_reference_clock,     // reference clock
   input  wire logic        stage0_vco_out,            // analog stage 0 out
   input  wire logic        stage1_vco_out,            // analog stage 1 out
   input  wire logic        stage0_lock_raw,           // async lock, stage 0
   input  wire logic        stage1_lock_raw,           // async lock, stage 1
   output logic             stage0_power_down,         // stage 0 off
   output logic             stage1_power_down,         // stage 1 off
   output logic [31:0]      stage0_config,             // divider setup 0
   output logic [31:0]      stage1_config,             // divider setup 1
   output logic [31:0]      system_pll_ctl_out,        // system pll control
   output logic [31:0]      system_cfg0_out,           // system stage 0 setup
   output logic [31:0]      system_cfg1_out,           // system stage 1 setup
   output logic             pixel_stage0_output_node,  // stage 0 node
   output logic             pixel_pll_output,          // gated pll clock
   output logic             pixel_pll_output_inverted, // gated inverted clock
   output logic             pixel_clock_run,           // gate open
   input  wire logic        link_superspeed,           // 1: U states valid
   input  wire logic [1:0]  lpm_state,                 // L0..L3
   input  wire logic [1:0]  u_state,                   // U0..U3
   input  wire logic        datapath_ready,            // datapath set up
   output logic             module_power_down,         // suspend modules
   output logic             signaling_off,             // no data signaling
   output logic             device_configured          // configured state
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic        pixel_clock_gate;
   logic        pixel_stage1_bypass;
   logic        pixel_stage0_bypass;
   logic        pixel_stage1_hold;
   logic        pixel_stage0_hold;
   logic [31:0] pm_ctl;
   logic [1:0]  lock_sync;
   logic        pixel_stage0_locked;
   logic        pixel_stage1_locked;
   ppc_pkg::ppc_pm_t pm_state;
   ppc_pkg::ppc_pm_t next_pm_state;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   wire hit_pctl  = csr_addr == ppc_pkg::PIX_CTL_OFS;
   wire hit_pcfg0 = csr_addr == ppc_pkg::PIX_CFG0_OFS;
   wire hit_pcfg1 = csr_addr == ppc_pkg::PIX_CFG1_OFS;
   wire hit_sctl  = csr_addr == ppc_pkg::SYS_CTL_OFS;
   wire hit_scfg0 = csr_addr == ppc_pkg::SYS_CFG0_OFS;
   wire hit_scfg1 = csr_addr == ppc_pkg::SYS_CFG1_OFS;
   wire hit_pm    = csr_addr == ppc_pkg::PM_CTL_OFS;
   wire wr_ok     = csr_wr & ~csr_rd;

   function automatic logic [31:0] masked(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] mask);
      masked = (new_v & mask) | (old_v & ~mask);
   endfunction

   // ------------------------------------------------------------
   // lock synchroniser
   // ------------------------------------------------------------
   ppc_lock_sync #(
      .WIDTH (2)
   ) ppc_lock_sync_i (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({stage1_lock_raw, stage0_lock_raw}),
      .sync_out (lock_sync)
   );

   assign pixel_stage0_locked = lock_sync[0];
   assign pixel_stage1_locked = lock_sync[1];

   // ------------------------------------------------------------
   // pixel control and configuration registers
   // ------------------------------------------------------------
   // whole bank on the crystal clock so it works with both plls off
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pixel_clock_gate    <= ppc_pkg::GATE_RST;
         pixel_stage1_bypass <= ppc_pkg::BYPASS1_RST;
         pixel_stage0_bypass <= ppc_pkg::BYPASS0_RST;
         pixel_stage1_hold   <= ppc_pkg::HOLD1_RST;
         pixel_stage0_hold   <= ppc_pkg::HOLD0_RST;
      end else if (wr_ok && hit_pctl) begin
         pixel_clock_gate    <= csr_wdata[ppc_pkg::GATE_BIT];
         pixel_stage1_bypass <= csr_wdata[ppc_pkg::BYPASS1_BIT];
         pixel_stage0_bypass <= csr_wdata[ppc_pkg::BYPASS0_BIT];
         pixel_stage1_hold   <= csr_wdata[ppc_pkg::HOLD1_BIT];
         pixel_stage0_hold   <= csr_wdata[ppc_pkg::HOLD0_BIT];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage0_config      <= ppc_pkg::CFG_RST;
         stage1_config      <= ppc_pkg::CFG_RST;
         system_pll_ctl_out <= ppc_pkg::SYS_RST;
         system_cfg0_out    <= ppc_pkg::SYS_RST;
         system_cfg1_out    <= ppc_pkg::SYS_RST;
         pm_ctl             <= ppc_pkg::PM_RST;
      end else if (wr_ok) begin
         if (hit_pcfg0) stage0_config <= masked(stage0_config, csr_wdata, ppc_pkg::CFG_WR_MASK);
         if (hit_pcfg1) stage1_config <= masked(stage1_config, csr_wdata, ppc_pkg::CFG_WR_MASK);
         if (hit_sctl)
            system_pll_ctl_out <= masked(system_pll_ctl_out, csr_wdata, ppc_pkg::SYS_WR_MASK);
         if (hit_scfg0)
            system_cfg0_out <= masked(system_cfg0_out, csr_wdata, ppc_pkg::SYS_WR_MASK);
         if (hit_scfg1)
            system_cfg1_out <= masked(system_cfg1_out, csr_wdata, ppc_pkg::SYS_WR_MASK);
         if (hit_pm) pm_ctl <= masked(pm_ctl, csr_wdata, ppc_pkg::PM_WR_MASK);
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   logic [31:0] pctl_view;
   logic [31:0] pm_view;
   logic [31:0] next_rdata;

   always_comb begin
      pctl_view = '0;
      pctl_view[ppc_pkg::GATE_BIT]    = pixel_clock_gate;
      pctl_view[ppc_pkg::LOCK1_BIT]   = pixel_stage1_locked;
      pctl_view[ppc_pkg::LOCK0_BIT]   = pixel_stage0_locked;
      pctl_view[ppc_pkg::BYPASS1_BIT] = pixel_stage1_bypass;
      pctl_view[ppc_pkg::BYPASS0_BIT] = pixel_stage0_bypass;
      pctl_view[ppc_pkg::HOLD1_BIT]   = pixel_stage1_hold;
      pctl_view[ppc_pkg::HOLD0_BIT]   = pixel_stage0_hold;
      pm_view = pm_ctl;
      pm_view[ppc_pkg::PM_SUSP_BIT]  = module_power_down;
      pm_view[ppc_pkg::PM_QUIET_BIT] = signaling_off;
      pm_view[ppc_pkg::PM_CONF_BIT]  = device_configured;
   end

   // reserved and unmapped offsets fall through to zero
   assign next_rdata = hit_pctl  ? pctl_view :
                       hit_pcfg0 ? stage0_config :
                       hit_pcfg1 ? stage1_config :
                       hit_sctl  ? system_pll_ctl_out :
                       hit_scfg0 ? system_cfg0_out :
                       hit_scfg1 ? system_cfg1_out :
                       hit_pm    ? pm_view : '0;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         csr_rdata <= '0;
         csr_ack   <= 1'b0;
      end else begin
         csr_rdata <= csr_rd ? next_rdata : '0;
         csr_ack   <= csr_rd | csr_wr;
      end
   end

   // ------------------------------------------------------------
   // stage steering
   // ------------------------------------------------------------
   logic stage1_mux;

   assign stage0_power_down = pixel_stage0_hold | pixel_stage0_bypass;
   assign stage1_power_down = pixel_stage1_hold | pixel_stage1_bypass;
   assign pixel_stage0_output_node = pixel_stage0_hold   ? 1'b0 :
                                     pixel_stage0_bypass ? pixel_reference_clock :
                                     stage0_vco_out;
   assign stage1_mux = pixel_stage1_hold   ? 1'b0 :
                       pixel_stage1_bypass ? pixel_stage0_output_node :
                       stage1_vco_out;

   // gate opened only on a low clock phase is the job of the icg cell;
   // this path is the behavioural stand-in and opens on a clk edge in any phase of the gated clock
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) pixel_clock_run <= 1'b0;
      else         pixel_clock_run <= ~pixel_clock_gate;
   end

   assign pixel_pll_output          = pixel_clock_run & stage1_mux;
   assign pixel_pll_output_inverted = pixel_clock_run & ~stage1_mux & ~pixel_stage1_hold;

   // ------------------------------------------------------------
   // link power reaction
   // ------------------------------------------------------------
   wire pll_ready = pixel_clock_run & datapath_ready;

   always_comb begin
      next_pm_state = ppc_pkg::PPC_PM_RUN;
      if (link_superspeed) begin
         unique case (ppc_pkg::ppc_ulink_t'(u_state))
            ppc_pkg::PPC_U0: next_pm_state = ppc_pkg::PPC_PM_RUN;
            ppc_pkg::PPC_U1: next_pm_state = ppc_pkg::PPC_PM_IDLE;
            ppc_pkg::PPC_U2: next_pm_state = ppc_pkg::PPC_PM_IDLE;
            ppc_pkg::PPC_U3: next_pm_state = ppc_pkg::PPC_PM_SUSPEND;
         endcase
      end else begin
         unique case (ppc_pkg::ppc_lpm_t'(lpm_state))
            ppc_pkg::PPC_L0: next_pm_state = ppc_pkg::PPC_PM_RUN;
            ppc_pkg::PPC_L1: next_pm_state = ppc_pkg::PPC_PM_IDLE;
            ppc_pkg::PPC_L2: next_pm_state = ppc_pkg::PPC_PM_SUSPEND;
            ppc_pkg::PPC_L3: next_pm_state = ppc_pkg::PPC_PM_OFF;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) pm_state <= ppc_pkg::PPC_PM_OFF;
      else         pm_state <= next_pm_state;
   end

   // idle state deliberately powers nothing down: resume must stay short
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         module_power_down <= 1'b0;
         signaling_off     <= 1'b1;
         device_configured <= 1'b0;
      end else begin
         module_power_down <= next_pm_state == ppc_pkg::PPC_PM_SUSPEND;
         signaling_off     <= next_pm_state == ppc_pkg::PPC_PM_OFF;
         device_configured <= next_pm_state == ppc_pkg::PPC_PM_RUN && link_superspeed
                              && pll_ready;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_GATE_STOPS: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(pixel_clock_gate) |=> !pixel_clock_run && !pixel_pll_output)
      else $error("pixel clock not stopped after gate set");

   AST_GATE_RUNS: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_ok && hit_pctl && !csr_wdata[ppc_pkg::GATE_BIT]) |=> ##1 pixel_clock_run)
      else $error("pixel clock not restarted after gate cleared");

   AST_HOLD1_LOW: assert property (@(posedge clk) disable iff (sys_rst)
      pixel_stage1_hold |-> !pixel_pll_output && !pixel_pll_output_inverted && stage1_power_down)
      else $error("outputs not low under stage 1 hold");

   AST_HOLD0_LOW: assert property (@(posedge clk) disable iff (sys_rst)
      pixel_stage0_hold |-> !pixel_stage0_output_node && stage0_power_down)
      else $error("stage 0 node not low under hold");

   AST_BYPASS0_REF: assert property (@(posedge clk) disable iff (sys_rst)
      (pixel_stage0_bypass && !pixel_stage0_hold)
         |-> pixel_stage0_output_node == pixel_reference_clock && stage0_power_down)
      else $error("stage 0 node not following reference");

   AST_BYPASS1_NODE: assert property (@(posedge clk) disable iff (sys_rst)
      (pixel_stage1_bypass && !pixel_stage1_hold && pixel_clock_run)
         |-> pixel_pll_output == pixel_stage0_output_node)
      else $error("output not following stage 0 node");

   AST_LOCK_DELAY: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(pixel_stage0_locked) |-> $past(stage0_lock_raw, 3))
      else $error("lock bit rose without synchronised source");

   AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      (csr_rd && csr_addr >= ppc_pkg::SPACE_BASE && csr_addr <= ppc_pkg::SPACE_LAST
       && !(hit_pctl | hit_pcfg0 | hit_pcfg1 | hit_sctl | hit_scfg0 | hit_scfg1 | hit_pm))
         |=> csr_ack && csr_rdata == 32'h0000_0000)
      else $error("reserved offset returned data");

   AST_SLEEP_NO_PD: assert property (@(posedge clk) disable iff (sys_rst)
      (!link_superspeed && lpm_state == 2'h1) |=> !module_power_down && !signaling_off)
      else $error("modules powered down in sleep");

   AST_U3_SUSPEND: assert property (@(posedge clk) disable iff (sys_rst)
      (link_superspeed && u_state == 2'h3) |=> module_power_down)
      else $error("U3 not handled as suspend");

   AST_CONF_NEEDS_PLL: assert property (@(posedge clk) disable iff (sys_rst)
      device_configured |-> $past(pixel_clock_run) && $past(datapath_ready))
      else $error("configured without plls and datapath ready");

   AST_L3_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      (!link_superspeed && lpm_state == 2'h3)
         |=> pm_state == ppc_pkg::PPC_PM_OFF && signaling_off && !module_power_down)
      else $error("L3 not handled as signaling off");

endmodule

// ===== bench/ppc_pll_model.sv
// behavioural analog pixel pll macro: two stage vcos and lock detectors
// assumes: power-down levels come from the clock control block on clk
`timescale 1ns/100ps
module ppc_pll_model #(
   parameter int LOCK_CYC = 20
) (
   input  wire logic clk,               // crystal clock
   input  wire logic stage0_power_down, // stage 0 off
   input  wire logic stage1_power_down, // stage 1 off
   output logic      stage0_vco_out,    // stage 0 vco
   output logic      stage1_vco_out,    // stage 1 vco
   output logic      stage0_lock_raw,   // async lock 0
   output logic      stage1_lock_raw    // async lock 1
);
   int cnt0 = 0;
   int cnt1 = 0;
   initial stage0_vco_out = 1'b0;
   initial stage1_vco_out = 1'b0;
   // a powered-down stage has no oscillation and no lock
   always #3 stage0_vco_out = stage0_power_down ? 1'b0 : ~stage0_vco_out;
   always #2 stage1_vco_out = stage1_power_down ? 1'b0 : ~stage1_vco_out;
   always @(posedge clk) begin
      cnt0 <= stage0_power_down ? 0 : cnt0 + 1;
      cnt1 <= stage1_power_down ? 0 : cnt1 + 1;
   end
   // skewed off clk on purpose: lock detectors are not in our domain
   assign #1.3 stage0_lock_raw = (cnt0 > LOCK_CYC);
   assign #2.7 stage1_lock_raw = (cnt1 > LOCK_CYC);
endmodule

// ===== bench/pixel_pll_control_and_power_states_tb_top.sv
// self-checking bench for the pixel clock and power control block
// assumes: ppc_pll_model stands in for the analog pll macro
`timescale 1ns/100ps
module pixel_pll_control_and_power_states_tb_top;
   localparam int LOCK_CYC = 20;
   logic        clk = 1'b0, sys_rst = 1'b1, csr_rd = 1'b0, csr_wr = 1'b0;
   logic [15:0] csr_addr = 16'h7000;
   logic [31:0] csr_wdata = 32'h0000_0000;
   logic        pixel_reference_clock = 1'b0, link_superspeed = 1'b0, datapath_ready = 1'b0;
   logic [1:0]  lpm_state = 2'h0, u_state = 2'h0;
   logic [31:0] csr_rdata, stage0_config, stage1_config, system_pll_ctl_out;
   logic [31:0] system_cfg0_out, system_cfg1_out;
   logic        csr_ack, stage0_vco_out, stage1_vco_out, stage0_lock_raw, stage1_lock_raw;
   logic        stage0_power_down, stage1_power_down, pixel_stage0_output_node;
   logic        pixel_pll_output, pixel_pll_output_inverted, pixel_clock_run;
   logic        module_power_down, signaling_off, device_configured;
   int          fail_count = 0, num_checks = 0, cyc = 0;

   ppc_clock_power ppc_clock_power_i (.clk, .sys_rst, .csr_rd, .csr_wr, .csr_addr,
      .csr_wdata, .csr_rdata, .csr_ack, .pixel_reference_clock, .stage0_vco_out,
      .stage1_vco_out, .stage0_lock_raw, .stage1_lock_raw, .stage0_power_down,
      .stage1_power_down, .stage0_config, .stage1_config, .system_pll_ctl_out,
      .system_cfg0_out, .system_cfg1_out, .pixel_stage0_output_node, .pixel_pll_output,
      .pixel_pll_output_inverted, .pixel_clock_run, .link_superspeed, .lpm_state,
      .u_state, .datapath_ready, .module_power_down, .signaling_off, .device_configured);
   ppc_pll_model #(.LOCK_CYC(LOCK_CYC)) ppc_pll_model_i (.clk, .stage0_power_down,
      .stage1_power_down, .stage0_vco_out, .stage1_vco_out, .stage0_lock_raw,
      .stage1_lock_raw);

   always #5 clk = ~clk;

   // ------------------------------------------------------------
   // checking and access tasks
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // strobe is a one-cycle pulse; the idle edge after it avoids re-driving in one step
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      csr_addr = a;
      csr_wdata = d;
      csr_wr = 1'b1;
      @(posedge clk);
      #1 csr_wr = 1'b0;
      chk(csr_ack, 1'b1);
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      csr_addr = a;
      csr_rd = 1'b1;
      @(posedge clk);
      #1 csr_rd = 1'b0;
      chk(csr_ack, 1'b1);
      chk(csr_rdata, exp);
      @(posedge clk);
      #1;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rd(16'h7000, 32'h8000_000f);
      chk({pixel_stage0_output_node, pixel_pll_output, pixel_clock_run}, 3'h0);
      chk({stage1_power_down, stage0_power_down}, 2'h3);
      wr(16'h7000, 32'hffff_ffff);
      rd(16'h7000, 32'h8000_000f);
   endtask
   task automatic t_map();
      logic [15:0] a [10] = '{16'h7004, 16'h7008, 16'h700c, 16'h7010, 16'h7014,
                               16'h7018, 16'h701c, 16'h7020, 16'h7024, 16'h7ffc};
      logic [31:0] m [10] = '{32'h0077_1fff, 32'h0077_1fff, '1, '1, '1, 0, 0, 1, 0, 0};
      for (int i = 0; i < 10; i++) begin
         wr(a[i], 32'hffff_ffff);
         rd(a[i], m[i]);
      end
      chk(stage1_config & system_cfg1_out, 32'h0077_1fff);
      chk(stage0_config, 32'h0077_1fff);
      chk(system_pll_ctl_out & system_cfg0_out, 32'hffff_ffff);
   endtask
   task automatic t_path();
      wr(16'h7000, 32'h0000_000c);
      for (int v = 0; v < 2; v++) begin
         pixel_reference_clock = v[0];
         #1 chk(pixel_stage0_output_node, v[0]);
         chk({pixel_pll_output, pixel_pll_output_inverted}, {v[0], ~v[0]});
      end
      chk({pixel_clock_run, stage1_power_down, stage0_power_down}, 3'h7);
      wr(16'h7000, 32'h0000_000e);
      chk({pixel_pll_output, pixel_pll_output_inverted}, 2'h0);
      chk(pixel_stage0_output_node, 1'b1);
      wr(16'h7000, 32'h0000_000d);
      chk({pixel_stage0_output_node, pixel_pll_output}, 2'h0);
      wr(16'h7000, 32'h8000_000c);
      chk({pixel_clock_run, pixel_pll_output}, 2'h0);
   endtask
   task automatic t_lock();
      wr(16'h7000, 32'h8000_0000);
      chk({stage1_power_down, stage0_power_down}, 2'h0);
      // wait by time, never poll the lock bits: they may never assert
      repeat (LOCK_CYC + 10) @(posedge clk);
      #1 rd(16'h7000, 32'h8000_0030);
      wr(16'h7000, 32'h0000_0000);
      chk(pixel_clock_run, 1'b1);
   endtask
   task automatic t_pm();
      for (int i = 0; i < 4; i++) begin
         lpm_state = i[1:0];
         @(posedge clk);
         #1 chk({module_power_down, signaling_off}, {i == 2, i == 3});
      end
      link_superspeed = 1'b1;
      datapath_ready = 1'b1;
      for (int i = 0; i < 4; i++) begin
         u_state = i[1:0];
         @(posedge clk);
         #1 chk({module_power_down, device_configured}, {i == 3, i == 0});
      end
      rd(16'h7020, 32'h0000_0011);
      u_state = 2'h0;
      datapath_ready = 1'b0;
      @(posedge clk);
      #1 chk(device_configured, 1'b0);
   endtask
   // mid-run reset: pixel control, stage 0 config and system stage 0 setup back to reset values
   task automatic t_rerst();
      sys_rst = 1'b1;
      @(posedge clk);
      #1 sys_rst = 1'b0;
      rd(16'h7000, 32'h8000_000f);
      chk({pixel_clock_run, pixel_pll_output, pixel_pll_output_inverted}, 3'h0);
      chk(stage0_config | system_cfg0_out, 32'h0000_0000);
   endtask

   // ------------------------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      #1 sys_rst = 1'b0;
      t_reset();
      t_map();
      t_path();
      t_lock();
      t_pm();
      t_rerst();
      stop_test();
   end
endmodule
